// file: mbb_bridge.sv
// Purpose: Bus adapter bridge with write buffer and read prefetch
// Assumes: Bus strobes are asynchronous, node link and CPU on this clock
// Notes: Node link requests are levels held until the node acknowledges
`timescale 1ns/10ps
// Operation
// - Decode a 24-bit bus address covering sixteen megabytes.
// - Lowest four megabytes reach node memory at the same address.
// - Window 400000H above reaches the same memory byte swapped.
// - Swap exchanges word bytes; byte accesses invert address bit zero.
// - 800000H up to BF0000 is device space, never claimed.
// - The 64-kilobyte block at BF0000 posts events.
// - Translation comes from a writable mapping RAM, conventional by default.
// - Node word and byte accesses supported; longwords take two cycles.
// - Bus writes always pipelined; reads only when enabled.
// - Auxiliary control bit 3 enables pipelined reads.
// - Pipeline serves byte and word accesses alike.
// - Node-originated transfers bypass the pipeline.
// - Bus writes latch, acknowledge at once, finish to node later.
// - Pipelined read prefetches the address two above.
// - Pipeline empty after reset or other operations, full after pipelined read.
// - Node delays up to 25 microseconds are waited out, not faulted.
// - Fast acknowledge about 0.3 microseconds after the access begins.
// - Byte equals word time; longword takes twice.
// - Node cycle starts on address strobe; bus cycle on bus request.
// - Event write is translated and flagged as event post.
// - Event map entries are special with segment from entry bits 5-0, zero by default.
module mbb_bridge
	import mbb_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic mb_bus_req,
	input wire logic mb_reset,
	input wire logic [23:0] mb_addr,
	input wire logic mb_write,
	input wire logic mb_byte,
	input wire logic [15:0] mb_wdata,
	output logic mb_xack,
	output logic [15:0] mb_rdata,
	output logic nd_req,
	output logic [21:0] nd_addr,
	output logic nd_write,
	output logic nd_byte,
	output logic nd_event,
	output logic [15:0] nd_wdata,
	input wire logic nd_ack,
	input wire logic [15:0] nd_rdata,
	input wire logic cpu_as,
	input wire logic [31:0] cpu_addr,
	input wire logic cpu_write,
	input wire logic [1:0] cpu_size,
	input wire logic [31:0] cpu_wdata,
	output logic cpu_ack,
	output logic [31:0] cpu_rdata,
	output logic mbm_req,
	output logic [23:0] mbm_addr,
	output logic mbm_write,
	output logic mbm_byte,
	output logic [15:0] mbm_wdata,
	input wire logic mbm_ack,
	input wire logic [15:0] mbm_rdata
);
	typedef enum {S_IDLE, S_DEC, S_FAST, S_NODE, S_PF, S_HOLD} mbb_slv_t;
	typedef enum {M_IDLE, M_RUN, M_DROP, M_END} mbb_mst_t;

	// ----------------------------------------------------------------
	// Pin synchronisers and map RAM
	// ----------------------------------------------------------------
	logic req_s;
	logic rst_s;
	logic ack_s;
	logic req_q;
	mbb_map_if map_bus();

	mbb_pin_sync #(.W(3)) u_sync (
		.clock(clock),
		.reset_n(reset_n),
		.pin({mb_bus_req, mb_reset, mbm_ack}),
		.level({req_s, rst_s, ack_s})
	);

	mbb_map_ram u_map (
		.clock(clock),
		.reset_n(reset_n),
		.port(map_bus.ram)
	);

	// ----------------------------------------------------------------
	// Slave side state
	// ----------------------------------------------------------------
	mbb_slv_t st;
	mbb_mst_t ms;
	logic [23:0] cur_addr;
	logic cur_wr;
	logic cur_byte;
	logic [15:0] cur_wdata;
	logic [5:0] ack_cnt;
	logic pipe_full;
	logic [23:0] pf_addr;
	logic [15:0] pf_data;
	logic lk_pf;
	logic [11:0] wait_cnt;
	logic late;
	logic [15:0] aux;
	logic m_long;
	logic m_second;

	// Address decode on the latched bus address
	wire rg_direct = cur_addr[23:22] == MB_DIRECT_QTR;
	wire rg_swap = cur_addr[23:22] == MB_SWAP_QTR;
	wire rg_evt = cur_addr[23:16] == MB_EVT_BLK;
	wire claimed = rg_direct | rg_swap | (rg_evt & cur_wr);
	wire pipe_en = aux[AUX_PIPE_BIT];
	wire hit = pipe_en & pipe_full & !cur_wr & (cur_addr == pf_addr);
	wire req_rise = req_s & !req_q;
	wire ack_due = ack_cnt >= ACK_CYC;

	// Launch decisions for the node link
	wire [23:0] pf_next = cur_addr + PF_STEP;
	wire pf_go = (st == S_FAST && ack_due && !cur_wr) || st == S_PF;
	wire dec_go = st == S_DEC && claimed && !nd_req && !hit && !rst_s;
	wire ln_go = dec_go | pf_go;
	wire [23:0] lk_addr = pf_go ? pf_next : cur_addr;
	wire lk_swap = lk_addr[23:22] == MB_SWAP_QTR;
	wire ln_byte = cur_byte & !pf_go;
	wire [6:0] lk_entry = map_bus.lk_entry;
	wire [21:0] ln_addr = {lk_entry[5:0], lk_addr[15:1], lk_addr[0] ^ (ln_byte & lk_swap)};
	wire [15:0] ln_wdata = (rg_swap & !cur_byte) ? swap16(cur_wdata) : cur_wdata;
	wire [15:0] rd_view = (rg_swap & !cur_byte) ? swap16(nd_rdata) : nd_rdata;
	wire [15:0] pf_view = (rg_swap & !cur_byte) ? swap16(pf_data) : pf_data;
	wire nd_done = nd_req & nd_ack;

	// Node-side decode
	wire m_start = ms == M_IDLE && cpu_as;
	wire sel_aux = cpu_addr == AUX_ADDR;
	wire sel_map = cpu_addr[31:12] == MAP_BASE_HI;
	wire sel_mbm = cpu_addr[31:24] == MBM_WIN_HI;
	wire aux_wr = m_start & sel_aux & cpu_write;
	wire [15:0] aux_view = {aux[15:6], late, pipe_full, aux[3:0]};
	wire [15:0] m_first = (cpu_size == SZ_LONG) ? cpu_wdata[31:16] : cpu_wdata[15:0];

	assign map_bus.lk_index = lk_addr[23:16];
	assign map_bus.wr_en = m_start & sel_map & cpu_write;
	assign map_bus.acc_index = cpu_addr[8:1];
	assign map_bus.wr_data = cpu_wdata[6:0];

	// ----------------------------------------------------------------
	// Bus slave sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			req_q <= 1'b0;
			ack_cnt <= 6'h00;
		end else begin
			req_q <= req_s;
			ack_cnt <= (st == S_IDLE) ? 6'h01 : (ack_cnt + {5'h00, ~&ack_cnt});
		end
	end

	// Latch the request; the write is buffered here while node catches up
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cur_addr <= 24'h000000;
			cur_wr <= 1'b0;
			cur_byte <= 1'b0;
			cur_wdata <= 16'h0000;
		end else if (st == S_IDLE && req_rise) begin
			cur_addr <= mb_addr;
			cur_wr <= mb_write;
			cur_byte <= mb_byte;
			cur_wdata <= mb_wdata;
		end
	end

	// Slave state machine; a bus reset drops any answer in progress
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st <= S_IDLE;
			mb_xack <= 1'b0;
			mb_rdata <= 16'h0000;
		end else if (rst_s) begin
			st <= S_IDLE;
			mb_xack <= 1'b0;
		end else begin
			case (st)
				S_IDLE: begin
					if (req_rise) begin
						st <= S_DEC;
					end
				end
				S_DEC: begin
					if (!claimed) begin
						st <= S_HOLD;
					end else if (!nd_req) begin
						if (cur_wr || hit) begin
							st <= S_FAST;
						end else begin
							st <= S_NODE;
						end
						if (hit) begin
							mb_rdata <= pf_view;
						end
					end
				end
				S_FAST: begin
					if (ack_due) begin
						mb_xack <= 1'b1;
						st <= S_HOLD;
					end
				end
				S_NODE: begin
					if (nd_done && !lk_pf) begin
						mb_rdata <= rd_view;
						mb_xack <= 1'b1;
						st <= pipe_en ? S_PF : S_HOLD;
					end
				end
				S_PF: begin
					st <= S_HOLD;
				end
				S_HOLD: begin
					if (!req_s) begin
						mb_xack <= 1'b0;
						st <= S_IDLE;
					end
				end
				default: begin
					st <= S_IDLE;
				end
			endcase
		end
	end

	// Pipeline occupancy; only a pipelined read leaves it full
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pipe_full <= 1'b0;
			pf_addr <= 24'h000000;
		end else begin
			if (rst_s || (m_start && sel_mbm)) begin
				pipe_full <= 1'b0;
			end else if (st == S_DEC && (!claimed || !nd_req)) begin
				pipe_full <= hit;
			end else if (st == S_PF) begin
				pipe_full <= 1'b1;
			end
			if (pf_go) begin
				pf_addr <= pf_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// Node link requests, held until acknowledged
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			nd_req <= 1'b0;
			nd_addr <= 22'h000000;
			nd_write <= 1'b0;
			nd_byte <= 1'b0;
			nd_event <= 1'b0;
			nd_wdata <= 16'h0000;
			lk_pf <= 1'b0;
		end else if (ln_go) begin
			nd_req <= 1'b1;
			nd_addr <= ln_addr;
			nd_write <= cur_wr & !pf_go;
			nd_byte <= ln_byte;
			nd_event <= rg_evt & !pf_go;
			nd_wdata <= ln_wdata;
			lk_pf <= pf_go;
		end else if (nd_done) begin
			nd_req <= 1'b0;
		end
	end

	// Prefetched word and a sticky slow-response flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pf_data <= 16'h0000;
			wait_cnt <= 12'h000;
			late <= 1'b0;
		end else begin
			if (nd_done && lk_pf) begin
				pf_data <= nd_rdata;
			end
			wait_cnt <= nd_req ? (wait_cnt + {11'h000, ~&wait_cnt}) : 12'h000;
			if (nd_req && wait_cnt == NODE_WAIT_CYC) begin
				late <= 1'b1;
			end else if (aux_wr && cpu_wdata[AUX_LATE_BIT]) begin
				late <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Node-originated accesses, never through the pipeline
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			aux <= AUX_RESET;
		end else if (aux_wr) begin
			aux <= cpu_wdata[15:0];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ms <= M_IDLE;
			cpu_ack <= 1'b0;
			cpu_rdata <= 32'h00000000;
			mbm_req <= 1'b0;
			mbm_addr <= 24'h000000;
			mbm_write <= 1'b0;
			mbm_byte <= 1'b0;
			mbm_wdata <= 16'h0000;
			m_long <= 1'b0;
			m_second <= 1'b0;
		end else begin
			case (ms)
				M_IDLE: begin
					if (m_start && sel_mbm) begin
						mbm_req <= 1'b1;
						mbm_addr <= cpu_addr[23:0];
						mbm_write <= cpu_write;
						mbm_byte <= cpu_size == SZ_BYTE;
						mbm_wdata <= m_first;
						m_long <= cpu_size == SZ_LONG;
						m_second <= 1'b0;
						ms <= M_RUN;
					end else if (m_start) begin
						cpu_rdata <= sel_aux ? {16'h0000, aux_view} :
							sel_map ? {25'h0000000, map_bus.rd_entry} : 32'h00000000;
						cpu_ack <= 1'b1;
						ms <= M_END;
					end
				end
				M_RUN: begin
					if (ack_s) begin
						mbm_req <= 1'b0;
						if (m_long && !m_second) begin
							cpu_rdata[31:16] <= mbm_rdata;
						end else begin
							cpu_rdata[15:0] <= mbm_rdata;
						end
						ms <= M_DROP;
					end
				end
				M_DROP: begin
					if (!ack_s && m_long && !m_second) begin
						m_second <= 1'b1;
						mbm_addr <= mbm_addr + PF_STEP;
						mbm_wdata <= cpu_wdata[15:0];
						mbm_req <= 1'b1;
						ms <= M_RUN;
					end else if (!ack_s) begin
						cpu_ack <= 1'b1;
						ms <= M_END;
					end
				end
				M_END: begin
					cpu_ack <= 1'b0;
					if (!cpu_as) begin
						ms <= M_IDLE;
					end
				end
				default: begin
					ms <= M_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	localparam int MAX_GAP = 40;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	property p_fast_ack;
		$rose(mb_xack) && $past(st) == S_FAST |-> $past(ack_cnt) >= ACK_CYC;
	endproperty
	a_fast_ack: assert property (p_fast_ack) else $error("fast acknowledge too early");

	property p_write_empties;
		st == S_DEC && claimed && cur_wr && !nd_req && !rst_s |=> !pipe_full && st == S_FAST;
	endproperty
	a_write_empties: assert property (p_write_empties) else $error("write left pipe full");

	property p_pf_step;
		$rose(nd_req) && lk_pf |-> pf_addr == $past(cur_addr) + PF_STEP;
	endproperty
	a_pf_step: assert property (p_pf_step) else $error("prefetch not two above");

	property p_pf_gated;
		$rose(nd_req) && lk_pf |-> $past(pipe_en) && !nd_write;
	endproperty
	a_pf_gated: assert property (p_pf_gated) else $error("prefetch while disabled");

	property p_word_swap;
		$rose(nd_req) && nd_write && !nd_byte && cur_addr[23:22] == MB_SWAP_QTR
			|-> nd_wdata == swap16(cur_wdata);
	endproperty
	a_word_swap: assert property (p_word_swap) else $error("word not swapped");

	property p_direct_addr;
		$rose(nd_req) && !lk_pf && rg_direct && !map_bus.lk_entry[MAP_SPECIAL_BIT]
			&& cur_addr[23:16] == {2'h0, nd_addr[21:16]} |-> nd_addr[15:0] == cur_addr[15:0];
	endproperty
	a_direct_addr: assert property (p_direct_addr) else $error("direct address altered");

	property p_event_flag;
		$rose(nd_req) && !lk_pf && rg_evt |-> nd_event && nd_write;
	endproperty
	a_event_flag: assert property (p_event_flag) else $error("event post not flagged");

	property p_io_unclaimed;
		st == S_DEC && !claimed && !rst_s |=> st == S_HOLD ##1 !mb_xack;
	endproperty
	a_io_unclaimed: assert property (p_io_unclaimed) else $error("device space claimed");

	property p_long_second;
		$fell(mbm_req) && m_long && !m_second |-> ##[1:MAX_GAP] $rose(mbm_req);
	endproperty
	a_long_second: assert property (p_long_second) else $error("longword missing second cycle");

	property p_bypass;
		$rose(mbm_req) |-> !pipe_full;
	endproperty
	a_bypass: assert property (p_bypass) else $error("node transfer kept pipe full");

	property p_aux_bit;
		aux_wr |=> pipe_en == $past(cpu_wdata[AUX_PIPE_BIT]);
	endproperty
	a_aux_bit: assert property (p_aux_bit) else $error("pipeline enable not written");

	c_hit: cover property (st == S_DEC && hit && !nd_req);
	c_event: cover property ($rose(nd_req) && nd_event);
	c_long: cover property (m_second && $rose(cpu_ack));
endmodule : mbb_bridge

// file: mbb_bridge_test.sv
// Purpose: Self-checking bench for the bus bridge with prefetch
// Assumes: Inputs change on the falling edge, outputs are sampled there too
// Notes: Node data is word address xor 5a5a, bus slave data is address xor c3c3
`timescale 1ns/10ps
module mbb_bridge_test
	import mbb_pkg::*;
();
	logic clock, reset_n, mb_bus_req, mb_reset, mb_write, mb_byte, mb_xack;
	logic nd_req, nd_write, nd_byte, nd_event, nd_ack, cpu_as, cpu_write, cpu_ack;
	logic mbm_req, mbm_write, mbm_byte, mbm_ack;
	logic [23:0] mb_addr, mbm_addr;
	logic [15:0] mb_wdata, mb_rdata, nd_wdata, nd_rdata, mbm_wdata, mbm_rdata;
	logic [21:0] nd_addr;
	logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, rd;
	logic [1:0] cpu_size;
	logic [11:0] nd_delay;
	logic [39:0] nd_seen;
	logic [1:0][40:0] mbm_seen;
	int err_total, checks, cyc;

	mbb_bridge dut (.clock(clock), .reset_n(reset_n), .mb_bus_req(mb_bus_req),
		.mb_reset(mb_reset), .mb_addr(mb_addr), .mb_write(mb_write), .mb_byte(mb_byte),
		.mb_wdata(mb_wdata), .mb_xack(mb_xack), .mb_rdata(mb_rdata), .nd_req(nd_req),
		.nd_addr(nd_addr), .nd_write(nd_write), .nd_byte(nd_byte), .nd_event(nd_event),
		.nd_wdata(nd_wdata), .nd_ack(nd_ack), .nd_rdata(nd_rdata), .cpu_as(cpu_as),
		.cpu_addr(cpu_addr), .cpu_write(cpu_write), .cpu_size(cpu_size),
		.cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .mbm_req(mbm_req),
		.mbm_addr(mbm_addr), .mbm_write(mbm_write), .mbm_byte(mbm_byte),
		.mbm_wdata(mbm_wdata), .mbm_ack(mbm_ack), .mbm_rdata(mbm_rdata));
	mbb_far_model far (.clock(clock), .nd_req(nd_req), .nd_addr(nd_addr),
		.nd_write(nd_write), .nd_event(nd_event), .nd_wdata(nd_wdata), .nd_ack(nd_ack),
		.nd_rdata(nd_rdata), .nd_delay(nd_delay), .nd_seen(nd_seen), .mbm_req(mbm_req),
		.mbm_addr(mbm_addr), .mbm_write(mbm_write), .mbm_wdata(mbm_wdata),
		.mbm_ack(mbm_ack), .mbm_rdata(mbm_rdata), .mbm_seen(mbm_seen));

	always #4 clock = ~clock;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [43:0] got, input logic [43:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic hang();
		err_total++;
		wrap_up();
	endtask : hang

	// Register and bus-master window access from the node processor
	task automatic cpu_acc(input logic [31:0] a, input logic w, input logic [1:0] sz,
		input logic [31:0] d);
		int k;
		@(negedge clock);
		cpu_addr = a;
		cpu_write = w;
		cpu_size = sz;
		cpu_wdata = d;
		cpu_as = 1'b1;
		for (k = 0; k < 2000 && cpu_ack !== 1'b1; k++) @(negedge clock);
		rd = cpu_rdata;
		cpu_as = 1'b0;
		if (k == 2000) hang();
	endtask : cpu_acc

	// Bus master cycle; a refused one simply gives up after a short wait
	task automatic mb_acc(input logic [23:0] a, input logic w, input logic b,
		input logic [15:0] d, input logic want);
		int k;
		@(negedge clock);
		mb_addr = a;
		mb_write = w;
		mb_byte = b;
		mb_wdata = d;
		mb_bus_req = 1'b1;
		for (k = 0; k < (want ? 4000 : 100) && mb_xack !== 1'b1; k++) @(negedge clock);
		cyc = k;
		rd = {15'h0000, mb_xack, mb_rdata};
		mb_bus_req = 1'b0;
		if (want && k == 4000) hang();
		for (k = 0; k < 40 && mb_xack !== 1'b0; k++) @(negedge clock);
		// Request stays low past the pin filter, or a refused cycle never ends
		repeat (6) @(negedge clock);
		if (k == 40) hang();
	endtask : mb_acc

	// Posted work must drain before the next transfer is timed
	task automatic idle();
		int k;
		for (k = 0; k < 5000 && nd_req !== 1'b0; k++) @(negedge clock);
		if (k == 5000) hang();
		repeat (2) @(negedge clock);
	endtask : idle

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{clock, reset_n, mb_bus_req, mb_reset, mb_write, mb_byte, cpu_as, cpu_write} = '0;
		{mb_addr, mb_wdata, cpu_addr, cpu_wdata, cpu_size} = '0;
		{err_total, checks, cyc} = '0;
		nd_delay = 12'h0c8;
		repeat (16) @(negedge clock);
		reset_n = 1'b1;
		cpu_acc(AUX_ADDR, 1'b0, SZ_WORD, 32'h0);
		check(rd[15:0], AUX_RESET);
		cpu_acc(32'hfff70000, 1'b0, SZ_WORD, 32'h0);
		check(rd, 32'h0);
		$display("test registers done");
		mb_acc(24'h000100, 1'b1, 1'b0, 16'h1234, 1'b1);
		check(cyc >= 38 && cyc <= 44, 1'b1);
		idle();
		check(nd_seen, {2'b01, 22'h000100, 16'h1234});
		mb_acc(24'h400200, 1'b1, 1'b0, 16'h1234, 1'b1);
		idle();
		check(nd_seen, {2'b01, 22'h000200, 16'h3412});
		mb_acc(24'h400201, 1'b1, 1'b1, 16'h00ab, 1'b1);
		check(cyc >= 38 && cyc <= 44, 1'b1);
		idle();
		check(nd_seen[37:16], 22'h000200);
		mb_acc(24'h000300, 1'b0, 1'b0, 16'h0, 1'b1);
		check({cyc > 200, rd[15:0]}, {1'b1, 16'h595a});
		mb_acc(24'h400300, 1'b0, 1'b0, 16'h0, 1'b1);
		check(rd[15:0], 16'h5a59);
		$display("test windows done");
		cpu_acc(AUX_ADDR, 1'b1, SZ_WORD, 32'h0008);
		mb_acc(24'h000400, 1'b0, 1'b0, 16'h0, 1'b1);
		check(rd[15:0], 16'h0400 ^ 16'h5a5a);
		idle();
		check(nd_seen[37:16], 22'h000402);
		cpu_acc(AUX_ADDR, 1'b0, SZ_WORD, 32'h0);
		check(rd[15:0], 16'h0018);
		mb_acc(24'h000402, 1'b0, 1'b0, 16'h0, 1'b1);
		check({cyc <= 44, rd[15:0]}, {1'b1, 16'h0402 ^ 16'h5a5a});
		idle();
		check(nd_seen[37:16], 22'h000404);
		mb_acc(24'h000500, 1'b0, 1'b0, 16'h0, 1'b1);
		check(rd[15:0], 16'h0500 ^ 16'h5a5a);
		idle();
		mb_acc(24'h000600, 1'b1, 1'b0, 16'h0001, 1'b1);
		cpu_acc(AUX_ADDR, 1'b0, SZ_WORD, 32'h0);
		check(rd[15:0], 16'h0008);
		$display("test pipeline done");
		idle();
		mb_acc(24'hbf0010, 1'b1, 1'b0, 16'h0077, 1'b1);
		idle();
		check(nd_seen, {2'b11, 22'h000010, 16'h0077});
		cpu_acc(32'hfff7e17e, 1'b1, SZ_WORD, 32'h0045);
		mb_acc(24'hbf0020, 1'b1, 1'b0, 16'h0077, 1'b1);
		idle();
		check(nd_seen, {2'b11, 22'h050020, 16'h0077});
		cpu_acc(32'hfff7e17e, 1'b0, SZ_WORD, 32'h0);
		check(rd[6:0], 7'h45);
		mb_acc(24'h800000, 1'b0, 1'b0, 16'h0, 1'b0);
		check(rd[16], 1'b0);
		mb_acc(24'hbf0000, 1'b0, 1'b0, 16'h0, 1'b0);
		check(rd[16], 1'b0);
		mb_acc(24'hc00000, 1'b1, 1'b0, 16'h0, 1'b0);
		check(rd[16], 1'b0);
		$display("test events done");
		nd_delay = 12'h028;
		cpu_acc(32'hfe000100, 1'b1, SZ_LONG, 32'haabbccdd);
		check(mbm_seen[0], {1'b1, 24'h000100, 16'haabb});
		check(mbm_seen[1], {1'b1, 24'h000102, 16'hccdd});
		cpu_acc(32'hfe000200, 1'b0, SZ_LONG, 32'h0);
		check(rd, {16'h0200 ^ 16'hc3c3, 16'h0202 ^ 16'hc3c3});
		cpu_acc(32'hfe000300, 1'b0, SZ_WORD, 32'h0);
		check(rd[15:0], 16'h0300 ^ 16'hc3c3);
		$display("test node master done");
		nd_delay = 12'hc80;
		mb_acc(24'h000700, 1'b0, 1'b0, 16'h0, 1'b1);
		check(rd[15:0], 16'h0700 ^ 16'h5a5a);
		cpu_acc(AUX_ADDR, 1'b0, SZ_WORD, 32'h0);
		check(rd[15:0], 16'h0038);
		mb_reset = 1'b1;
		repeat (6) @(negedge clock);
		mb_reset = 1'b0;
		cpu_acc(AUX_ADDR, 1'b0, SZ_WORD, 32'h0);
		check(rd[15:0], 16'h0028);
		cpu_acc(AUX_ADDR, 1'b1, SZ_WORD, 32'h0028);
		cpu_acc(AUX_ADDR, 1'b0, SZ_WORD, 32'h0);
		check(rd[15:0], 16'h0008);
		$display("test late node done");
		wrap_up();
	end
endmodule : mbb_bridge_test

// file: mbb_far_model.sv
// Purpose: Node controller and bus slave stand-in for the bridge bench
// Assumes: Node answers with a pulse, bus slave with a level held until request falls
// Notes: Read data derives from the address so the bench can predict it
`timescale 1ns/10ps
module mbb_far_model (
	input wire logic clock,
	input wire logic nd_req,
	input wire logic [21:0] nd_addr,
	input wire logic nd_write,
	input wire logic nd_event,
	input wire logic [15:0] nd_wdata,
	output logic nd_ack,
	output logic [15:0] nd_rdata,
	input wire logic [11:0] nd_delay,
	output logic [39:0] nd_seen,
	input wire logic mbm_req,
	input wire logic [23:0] mbm_addr,
	input wire logic mbm_write,
	input wire logic [15:0] mbm_wdata,
	output logic mbm_ack,
	output logic [15:0] mbm_rdata,
	output logic [1:0][40:0] mbm_seen
);
	// ----------------------------------------------------------------
	// Node controller
	// ----------------------------------------------------------------
	// Delay is set by the bench so both stalled and prompt answers occur
	initial begin
		nd_ack = 1'b0;
		nd_rdata = 16'h0000;
		nd_seen = '0;
		forever begin
			@(posedge clock);
			if (nd_req) begin
				repeat (nd_delay) @(posedge clock);
				nd_seen <= {nd_event, nd_write, nd_addr, nd_wdata};
				nd_rdata <= {nd_addr[15:1], 1'b0} ^ 16'h5a5a;
				nd_ack <= 1'b1;
				@(posedge clock);
				nd_ack <= 1'b0;
				nd_rdata <= ~nd_rdata; // Stale data must never look valid
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// Cycles are logged alternately so a longword leaves both halves visible
	initial begin
		int n;
		n = 0;
		mbm_ack = 1'b0;
		mbm_rdata = 16'hffff;
		mbm_seen = '0;
		forever begin
			@(posedge clock);
			if (mbm_req && !mbm_ack) begin
				repeat (nd_delay[5:0]) @(posedge clock);
				mbm_seen[n] <= {mbm_write, mbm_addr, mbm_wdata};
				n = 1 - n;
				mbm_rdata <= mbm_addr[15:0] ^ 16'hc3c3;
				mbm_ack <= 1'b1;
			end else if (!mbm_req && mbm_ack) begin
				mbm_ack <= 1'b0;
				mbm_rdata <= ~mbm_rdata;
			end
		end
	end
endmodule : mbb_far_model

// file: mbb_map_if.sv
// Purpose: Lookup and access port of the address mapping RAM
// Assumes: Lookup is combinational, writes land on the clock edge
// Notes: One lookup index for translation, one index for node access
`timescale 1ns/10ps
interface mbb_map_if;
	logic [7:0] lk_index;
	logic [6:0] lk_entry;
	logic wr_en;
	logic [7:0] acc_index;
	logic [6:0] wr_data;
	logic [6:0] rd_entry;
	modport user(output lk_index, wr_en, acc_index, wr_data, input lk_entry, rd_entry);
	modport ram(input lk_index, wr_en, acc_index, wr_data, output lk_entry, rd_entry);
endinterface : mbb_map_if

// file: mbb_map_ram.sv
// Purpose: Writable bus-to-node address mapping RAM
// Assumes: 256 entries, one per 64-kilobyte bus block
// Notes: Entries never written return the conventional map
`timescale 1ns/10ps
module mbb_map_ram
	import mbb_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	mbb_map_if.ram port
);
	logic [MAP_W-1:0] mem [0:255];
	logic [255:0] prog;

	// Conventional entries without a reset of the whole array
	assign port.lk_entry = prog[port.lk_index] ? mem[port.lk_index] : conv_entry(port.lk_index);
	assign port.rd_entry = prog[port.acc_index] ? mem[port.acc_index] : conv_entry(port.acc_index);

	// Marks which entries software has rewritten
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prog <= '0;
		end else if (port.wr_en) begin
			prog[port.acc_index] <= 1'b1;
		end
	end

	// Storage of rewritten entries
	always_ff @(posedge clock) begin
		if (port.wr_en) begin
			mem[port.acc_index] <= port.wr_data;
		end
	end
endmodule : mbb_map_ram

// file: mbb_pin_sync.sv
// Purpose: Three-stage synchroniser for inputs from outside the clock
// Assumes: Each bit is an independent level
// Notes: A bit changes once stages two and three agree
`timescale 1ns/10ps
module mbb_pin_sync #(parameter int W = 1) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// First stage feeds only the second, agreement filters single glitches
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			level <= '0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			level <= (s2 & s3) | (level & (s2 ^ s3));
		end
	end
endmodule : mbb_pin_sync

// file: mbb_pkg.sv
// Purpose: Shared constants and helpers for the node bridge pipeline
// Assumes: 125 MHz core clock, 16-bit bus data, 24-bit bus addresses
// Notes: Offsets, register bits and timing cycle counts live here; the check bound MAX_GAP stays in the bridge
package mbb_pkg;

	// ----------------------------------------------------------------
	// Bus address map
	// ----------------------------------------------------------------
	localparam logic [1:0] MB_DIRECT_QTR = 2'h0;
	localparam logic [1:0] MB_SWAP_QTR = 2'h1;
	localparam logic [7:0] MB_EVT_BLK = 8'hbf;
	localparam logic [23:0] PF_STEP = 24'h000002;

	// ----------------------------------------------------------------
	// Node-side register map
	// ----------------------------------------------------------------
	localparam logic [31:0] AUX_ADDR = 32'hfff7d026;
	localparam logic [15:0] AUX_RESET = 16'h0000;
	localparam int AUX_PIPE_BIT = 3;
	localparam int AUX_FULL_BIT = 4;
	localparam int AUX_LATE_BIT = 5;
	localparam logic [19:0] MAP_BASE_HI = 20'hfff7e;
	localparam logic [7:0] MBM_WIN_HI = 8'hfe;
	localparam int MAP_SPECIAL_BIT = 6;
	localparam int MAP_W = 7;

	// ----------------------------------------------------------------
	// Node access sizes
	// ----------------------------------------------------------------
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 8;
	localparam int ACK_NS = 300;
	localparam int NODE_WAIT_NS = 25000;
	localparam logic [5:0] ACK_CYC = 6'(ACK_NS / CLK_NS);
	localparam logic [11:0] NODE_WAIT_CYC = 12'(NODE_WAIT_NS / CLK_NS);

	// Exchange the two bytes of a word
	function automatic logic [15:0] swap16(input logic [15:0] d);
		return {d[7:0], d[15:8]};
	endfunction : swap16

	// Conventional map entry: identity segment, event block marked special
	function automatic logic [MAP_W-1:0] conv_entry(input logic [7:0] idx);
		return (idx == MB_EVT_BLK) ? 7'h40 : {1'b0, idx[5:0]};
	endfunction : conv_entry

endpackage : mbb_pkg
